// ---- shared/tvc_pkg.sv ----
// Shared constants and types for the triple video converter control block
package tvc_pkg;
   // Register indices on the plain register port
   localparam logic [3:0] TVC_REG_CH_STRIDE = 4'h3;
   localparam logic [3:0] TVC_REG_CLAMP = 4'h0;
   localparam logic [3:0] TVC_REG_COARSE = 4'h1;
   localparam logic [3:0] TVC_REG_FINE = 4'h2;
   localparam logic [3:0] TVC_REG_CTRL = 4'h9;
   localparam logic [3:0] TVC_REG_STATUS = 4'ha;
   localparam logic [3:0] TVC_REG_GAIN_BASE = 4'hb;
   // Field positions
   localparam int TVC_CTRL_ALT_BIT = 0;
   localparam int TVC_ST_SYNC_BIT = 0;
   localparam int TVC_ST_CLAMP_BIT = 1;
   localparam int TVC_ST_OVFL_BIT = 2;
   localparam int TVC_ST_ORDER_BIT = 3;
   localparam int TVC_ST_PHASE_LSB = 4;
   // Values after reset
   localparam logic [7:0] TVC_CLAMP_RST = 8'h7f;
   localparam logic [6:0] TVC_COARSE_RST = 7'h20;
   localparam logic [4:0] TVC_FINE_RST = 5'h00;
   localparam logic [6:0] TVC_GAIN_RST = 7'h40;
   // Arithmetic constants, clamp offsets in half codes
   localparam int TVC_GAIN_SHIFT = 6;
   localparam logic [7:0] TVC_STD_ZERO_CODE = 8'h7f;
   localparam logic [7:0] TVC_ALT_MAX_CODE = 8'h20;
   localparam logic signed [12:0] TVC_ALT_BASE_HALF = 13'h00f0;
   localparam logic [6:0] TVC_GAIN_MAX = 7'h7f;
   localparam logic [6:0] TVC_GAIN_MIN = 7'h01;
   localparam logic [7:0] TVC_FULL_SCALE = 8'hff;
   localparam int TVC_FIFO_DEPTH = 8;
   // Rate limits
   localparam int TVC_MAX_RATE_MSPS = 110;
   localparam int TVC_CLK_MHZ = 40;

   typedef struct packed {
      logic [7:0] clamp;
      logic [6:0] coarse;
      logic [4:0] fine;
   } tvc_cfg_s;

   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } tvc_pix_s;

   typedef struct packed {
      logic [2:0] ovr;
      tvc_pix_s pix;
   } tvc_word_s;

   typedef enum logic [1:0] {
      TVC_PH_VIDEO = 2'b00,
      TVC_PH_CAL = 2'b01,
      TVC_PH_WAIT = 2'b10,
      TVC_PH_CLAMP = 2'b11
   } tvc_phase_e;
endpackage

// ---- hw/tvc_top.sv ----
// Clamp, gain calibration, range flags and sample output for three video channels
// How it works
// RULE1 - Clamp code spans -63.5..+64 or +120..+136
// RULE2 - Eight-bit clamp setting per channel drives level
// RULE3 - Clamp all channels only during clamp pulse
// RULE4 - Reset clamp code gives black at zero
// RULE5 - Delivered samples saturate to 0..255
// RULE6 - Reference routed to converter during line sync
// RULE7 - Sync result versus coarse preset steers gain
// RULE8 - Three seven-bit coarse gain presets
// RULE9 - Software keeps contrast presets within 32..99
// RULE10 - Five-bit fine trim per channel atop loop
// RULE11 - Software sets coarse before fine trim
// RULE12 - Calibrate at line start before clamp
// RULE13 - Consumer ignores samples during sync
// RULE14 - Per-channel out-of-range flag
// RULE15 - Sample and flag out one cycle later
// RULE16 - Sampling logic good up to 110 Msps
// RULE17 - Output is unsigned straight binary
// RULE18 - Outputs driven only while enable low
// RULE19 - Three identical channel instances, one clock
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Eight-deep word FIFO feeding the display driver stream
module tvc_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_q];

   // Storage write
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers, fill count and the registered full and empty views
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_q <= cnt_q + 1'b1;
            in_ready_o <= (cnt_q != (AW + 1)'(DEPTH - 1));
            out_valid_o <= 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - 1'b1;
            in_ready_o <= 1'b1;
            out_valid_o <= (cnt_q != (AW + 1)'(1));
         end
      end
   end
endmodule

// One colour channel: gain loop, clamp, saturation and range flag
module tvc_chan
   import tvc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire tvc_pkg::tvc_cfg_s cfg_i,
   input wire logic alt_i,
   input wire logic sync_i,
   input wire logic clamp_i,
   input wire logic [7:0] conv_i,
   output logic [7:0] sample_o,
   output logic ovr_o,
   output logic [6:0] gain_o
);
   logic [7:0] eff_gain;
   logic [15:0] vid_prod;
   logic [9:0] vid_lvl;
   logic [14:0] ref_prod;
   logic [8:0] ref_lvl;
   logic [9:0] black_q;
   logic [7:0] alt_code;
   logic signed [12:0] off_half;
   logic signed [13:0] half;
   logic signed [12:0] level;
   logic [7:0] sample_d;

   // Coarse loop gain plus fine trim scales the video path
   assign eff_gain = {1'b0, gain_o} + {3'b000, cfg_i.fine}; // RULE10
   assign vid_prod = conv_i * eff_gain; // RULE16
   assign vid_lvl = vid_prod[15:TVC_GAIN_SHIFT];
   // The loop sees coarse gain only, so the trim is not cancelled
   assign ref_prod = conv_i * gain_o;
   assign ref_lvl = ref_prod[14:TVC_GAIN_SHIFT];

   // Clamp code to a signed half-code offset
   assign alt_code = (cfg_i.clamp > TVC_ALT_MAX_CODE) ? TVC_ALT_MAX_CODE : cfg_i.clamp;
   assign off_half = alt_i ? ($signed({5'h00, alt_code}) + TVC_ALT_BASE_HALF) // RULE1
                           : ($signed({5'h00, cfg_i.clamp}) - $signed({5'h00, TVC_STD_ZERO_CODE}));
   assign half = $signed({3'b000, vid_lvl, 1'b0}) - $signed({3'b000, black_q, 1'b0})
                 + $signed({off_half[12], off_half});
   assign level = half[13:1];

   // Saturate to the unsigned output code range
   always_comb
   begin
      if (level < 0)
      begin
         sample_d = 8'h00; // RULE5
      end
      else if (level > $signed({5'h00, TVC_FULL_SCALE}))
      begin
         sample_d = TVC_FULL_SCALE; // RULE5
      end
      else
      begin
         sample_d = level[7:0]; // RULE17
      end
   end

   // Black level captured only while the clamp pulse is high
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         black_q <= '0;
      end
      else if (clamp_i)
      begin
         black_q <= vid_lvl; // RULE3
      end
   end

   // Gain loop steps toward the coarse preset during sync
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gain_o <= TVC_GAIN_RST;
      end
      else if (sync_i)
      begin
         if ((ref_lvl < {2'b00, cfg_i.coarse}) && (gain_o != TVC_GAIN_MAX))
         begin
            gain_o <= gain_o + 1'b1; // RULE7
         end
         else if ((ref_lvl > {2'b00, cfg_i.coarse}) && (gain_o != TVC_GAIN_MIN))
         begin
            gain_o <= gain_o - 1'b1; // RULE7
         end
      end
   end

   // Sample and range flag registered one cycle after the conversion
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sample_o <= 8'h00;
         ovr_o <= 1'b0;
      end
      else
      begin
         sample_o <= sample_d; // RULE15
         ovr_o <= (vid_lvl > {2'b00, TVC_FULL_SCALE}); // RULE14
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_black_hold;
      !clamp_i |=> $stable(black_q);
   endproperty
   a_black_hold: assert property (p_black_hold) else $error("black level moved outside clamp"); // RULE3

   property p_sat_high;
      (level > 13'sh00ff) |=> (sample_o == 8'hff);
   endproperty
   a_sat_high: assert property (p_sat_high) else $error("high sample not saturated"); // RULE5

   property p_sat_low;
      (level < 0) |=> (sample_o == 8'h00);
   endproperty
   a_sat_low: assert property (p_sat_low) else $error("low sample not floored"); // RULE5

   property p_gain_up;
      (sync_i && (ref_lvl < {2'b00, cfg_i.coarse}) && (gain_o != 7'h7f))
      |=> (gain_o == $past(gain_o) + 7'h01);
   endproperty
   a_gain_up: assert property (p_gain_up) else $error("gain did not rise below preset"); // RULE7

   property p_gain_down;
      (sync_i && (ref_lvl > {2'b00, cfg_i.coarse}) && (gain_o != 7'h01))
      |=> (gain_o == $past(gain_o) - 7'h01);
   endproperty
   a_gain_down: assert property (p_gain_down) else $error("gain did not fall above preset"); // RULE7

   property p_gain_idle;
      !sync_i |=> $stable(gain_o);
   endproperty
   a_gain_idle: assert property (p_gain_idle) else $error("gain changed outside sync"); // RULE7

   property p_ovr;
      (vid_lvl > 10'h0ff) |=> ovr_o;
   endproperty
   a_ovr: assert property (p_ovr) else $error("range flag missing"); // RULE14

   property p_ovr_low;
      (vid_lvl <= 10'h0ff) |=> !ovr_o;
   endproperty
   a_ovr_low: assert property (p_ovr_low) else $error("range flag without overrange"); // RULE14

   property p_latency;
      (!clamp_i && !sync_i) ##1 ($stable(conv_i) && $stable(cfg_i) && $stable(alt_i))
      |=> $stable(sample_o);
   endproperty
   a_latency: assert property (p_latency) else $error("sample not one cycle behind input"); // RULE15

   c_cal_step: cover property (sync_i ##1 $changed(gain_o));
   c_clamp: cover property (clamp_i ##1 !clamp_i);
   c_sat: cover property (sample_o == 8'hff ##1 ovr_o);
endmodule

// Top: register port, pin synchronisers, line phase tracking and outputs
module tvc_top
   import tvc_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic CLAMP_PULSE_I,
   input wire logic LINE_SYNC_IN_I,
   input wire logic OUT_EN_N_I,
   input wire tvc_pkg::tvc_pix_s CONV_I,
   output tvc_pkg::tvc_pix_s DATA_O,
   output logic DATA_OE_O,
   output logic RED_OVER_RANGE_O,
   output logic GREEN_OVER_RANGE_O,
   output logic BLUE_OVER_RANGE_O,
   output logic REF_SELECT_O,
   output logic CLAMP_ACTIVE_O,
   output tvc_pkg::tvc_pix_s CLAMP_LEVEL_O,
   output logic PIX_VALID_O,
   input wire logic PIX_READY_I,
   output tvc_pkg::tvc_word_s PIX_DATA_O
);
   tvc_cfg_s cfg_q [3];
   logic alt_q;
   logic [2:0] clp_meta_q;
   logic [2:0] clp_sync_q;
   logic sync_s;
   logic clamp_s;
   logic oe_n_s;
   logic [7:0] smp [3];
   logic [2:0] ovr;
   logic [6:0] gain [3];
   tvc_phase_e phase_q;
   logic ovfl_q;
   logic order_q;
   logic sync_d1_q;
   logic fifo_ready;
   logic [7:0] rd_d;
   logic [3:0] ch_addr;
   logic started_q;

   assign sync_s = clp_sync_q[1];
   assign clamp_s = clp_sync_q[0];
   assign oe_n_s = clp_sync_q[2];

   // Two-flop synchronisers for clamp, sync and enable pins
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         clp_meta_q <= 3'b100;
         clp_sync_q <= 3'b100;
      end
      else
      begin
         clp_meta_q <= {OUT_EN_N_I, LINE_SYNC_IN_I, CLAMP_PULSE_I};
         clp_sync_q <= clp_meta_q;
      end
   end

   // Software writes of per-channel settings and the range mode
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         for (int c = 0; c < 3; c++)
         begin
            cfg_q[c] <= '{clamp: TVC_CLAMP_RST, coarse: TVC_COARSE_RST, fine: TVC_FINE_RST}; // RULE4
         end
         alt_q <= 1'b0;
      end
      else if (REG_WR_I)
      begin
         for (int c = 0; c < 3; c++)
         begin
            if (REG_ADDR_I == 4'(c) * TVC_REG_CH_STRIDE + TVC_REG_CLAMP)
            begin
               cfg_q[c].clamp <= REG_WDATA_I; // RULE2
            end
            if (REG_ADDR_I == 4'(c) * TVC_REG_CH_STRIDE + TVC_REG_COARSE)
            begin
               cfg_q[c].coarse <= REG_WDATA_I[6:0]; // RULE8
            end
            if (REG_ADDR_I == 4'(c) * TVC_REG_CH_STRIDE + TVC_REG_FINE)
            begin
               cfg_q[c].fine <= REG_WDATA_I[4:0]; // RULE10
            end
         end
         if (REG_ADDR_I == TVC_REG_CTRL)
         begin
            alt_q <= REG_WDATA_I[TVC_CTRL_ALT_BIT]; // RULE1
         end
      end
   end

   // Read decode, unmapped addresses read zero
   always_comb
   begin
      rd_d = 8'h00;
      ch_addr = 4'h0;
      for (int c = 0; c < 3; c++)
      begin
         ch_addr = 4'(c) * TVC_REG_CH_STRIDE;
         if (REG_ADDR_I == ch_addr + TVC_REG_CLAMP)
         begin
            rd_d = cfg_q[c].clamp;
         end
         if (REG_ADDR_I == ch_addr + TVC_REG_COARSE)
         begin
            rd_d = {1'b0, cfg_q[c].coarse};
         end
         if (REG_ADDR_I == ch_addr + TVC_REG_FINE)
         begin
            rd_d = {3'b000, cfg_q[c].fine};
         end
         if (REG_ADDR_I == TVC_REG_GAIN_BASE + 4'(c))
         begin
            rd_d = {1'b0, gain[c]};
         end
      end
      if (REG_ADDR_I == TVC_REG_CTRL)
      begin
         rd_d = {7'h00, alt_q};
      end
      if (REG_ADDR_I == TVC_REG_STATUS)
      begin
         rd_d = {2'b00, phase_q, order_q, ovfl_q, clamp_s, sync_s};
      end
   end

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         REG_RDATA_O <= 8'h00;
      end
      else
      begin
         REG_RDATA_O <= REG_RD_I ? rd_d : 8'h00;
      end
   end

   // Line phase: calibration in sync, then clamp; clamp first is flagged
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         phase_q <= TVC_PH_VIDEO;
         order_q <= 1'b0;
      end
      else
      begin
         case (phase_q)
            TVC_PH_VIDEO: if (sync_s) phase_q <= TVC_PH_CAL;
            TVC_PH_CAL: if (!sync_s) phase_q <= TVC_PH_WAIT;
            TVC_PH_WAIT: if (clamp_s) phase_q <= TVC_PH_CLAMP; // RULE12
            TVC_PH_CLAMP: if (!clamp_s) phase_q <= TVC_PH_VIDEO;
            default: phase_q <= TVC_PH_VIDEO;
         endcase
         // Sticky order fault; set wins over the software clear
         if (clamp_s && (phase_q == TVC_PH_VIDEO || phase_q == TVC_PH_CAL))
         begin
            order_q <= 1'b1; // RULE12
         end
         else if (REG_WR_I && REG_ADDR_I == TVC_REG_STATUS && REG_WDATA_I[TVC_ST_ORDER_BIT])
         begin
            order_q <= 1'b0;
         end
      end
   end

   // Three identical channel slices on the one clock
   for (genvar c = 0; c < 3; c++)
   begin : g_ch
      tvc_chan u_chan ( // RULE19
         .clk_i(CORE_CLK_I),
         .rst_n_i(RESET_N_I),
         .cfg_i(cfg_q[c]),
         .alt_i(alt_q),
         .sync_i(sync_s),
         .clamp_i(clamp_s),
         .conv_i((c == 0) ? CONV_I.r : (c == 1) ? CONV_I.g : CONV_I.b),
         .sample_o(smp[c]),
         .ovr_o(ovr[c]),
         .gain_o(gain[c])
      );
   end

   assign DATA_O = '{r: smp[0], g: smp[1], b: smp[2]}; // RULE15
   assign RED_OVER_RANGE_O = ovr[0]; // RULE14
   assign GREEN_OVER_RANGE_O = ovr[1];
   assign BLUE_OVER_RANGE_O = ovr[2];

   // Mux select, clamp drive, output enable and clamp levels
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         REF_SELECT_O <= 1'b0;
         CLAMP_ACTIVE_O <= 1'b0;
         DATA_OE_O <= 1'b0;
         CLAMP_LEVEL_O <= '{r: TVC_CLAMP_RST, g: TVC_CLAMP_RST, b: TVC_CLAMP_RST};
         sync_d1_q <= 1'b0;
         started_q <= 1'b0;
      end
      else
      begin
         REF_SELECT_O <= sync_s; // RULE6
         CLAMP_ACTIVE_O <= clamp_s; // RULE3
         DATA_OE_O <= !oe_n_s; // RULE18
         CLAMP_LEVEL_O <= '{r: cfg_q[0].clamp, g: cfg_q[1].clamp, b: cfg_q[2].clamp}; // RULE2
         sync_d1_q <= sync_s;
         started_q <= started_q | REG_WR_I;
      end
   end

   // Stream to the display driver skips samples taken during sync
   tvc_fifo #(
      .WIDTH($bits(tvc_word_s)),
      .DEPTH(TVC_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESET_N_I),
      .in_valid_i(!sync_d1_q), // RULE13
      .in_ready_o(fifo_ready),
      .in_data_i({ovr, DATA_O}),
      .out_valid_o(PIX_VALID_O),
      .out_ready_i(PIX_READY_I),
      .out_data_o(PIX_DATA_O)
   );

   // Sticky overflow when a sample meets a full FIFO
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ovfl_q <= 1'b0;
      end
      else if (!sync_d1_q && !fifo_ready)
      begin
         ovfl_q <= 1'b1;
      end
      else if (REG_WR_I && REG_ADDR_I == TVC_REG_STATUS && REG_WDATA_I[TVC_ST_OVFL_BIT])
      begin
         ovfl_q <= 1'b0;
      end
   end

   default clocking tcb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);

   property p_ref_sel;
      sync_s |=> REF_SELECT_O;
   endproperty
   a_ref_sel: assert property (p_ref_sel) else $error("reference not routed in sync"); // RULE6

   property p_video_sel;
      !sync_s |=> !REF_SELECT_O;
   endproperty
   a_video_sel: assert property (p_video_sel) else $error("reference routed outside sync"); // RULE6

   property p_oe;
      !oe_n_s |=> DATA_OE_O;
   endproperty
   a_oe: assert property (p_oe) else $error("outputs not enabled"); // RULE18

   property p_oe_off;
      oe_n_s |=> !DATA_OE_O;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("outputs not released"); // RULE18

   property p_clamp_rst;
      !started_q |-> (cfg_q[0].clamp == 8'h7f && cfg_q[1].clamp == 8'h7f
                      && cfg_q[2].clamp == 8'h7f);
   endproperty
   a_clamp_rst: assert property (p_clamp_rst) else $error("reset clamp code wrong"); // RULE4

   property p_order;
      (phase_q == TVC_PH_VIDEO && clamp_s) |=> order_q;
   endproperty
   a_order: assert property (p_order) else $error("clamp before calibration not flagged"); // RULE12

   c_line: cover property (phase_q == TVC_PH_CAL ##[1:50] phase_q == TVC_PH_CLAMP);
   c_full: cover property (!fifo_ready ##1 PIX_READY_I);
endmodule
`default_nettype wire

// ---- tb/tvc_disp_model.sv ----
// Display driver model that accepts words from the pixel stream
`timescale 1ns/1ps
`default_nettype none
module tvc_disp_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic hold_i,
   input wire logic slow_i,
   output logic ready_o
);
   logic [3:0] lfsr_q;

   // Pattern source for uneven acceptance
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lfsr_q <= 4'h9;
      else
         lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
   end

   // Ready is stalled, uneven or prompt; only stream words are taken, never sync samples
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ready_o <= 1'b0;
      else
         ready_o <= !hold_i && (!slow_i || lfsr_q[0]);
   end
endmodule
`default_nettype wire

// ---- tb/tb_triple_video_adc_gain_clamp_ctrl.sv ----
// Self-checking bench for the three-channel clamp, gain and output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
   $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_triple_video_adc_gain_clamp_ctrl;
   import tvc_pkg::*;
   typedef struct {int due; logic [26:0] w;} tvc_note_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0, rd = 1'b0, clamp_pulse = 1'b0, snc = 1'b0, oe_n = 1'b0;
   logic hold = 1'b0, slow = 1'b0, str_chk = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rnd, rdata;
   tvc_pix_s conv = '0, data, clvl;
   tvc_word_s pword;
   logic oe, red_over_range, green_over_range, bor, refsel, clact, pv, pr;
   wire [23:0] pins = oe ? data : 24'hzzzzzz;
   int err_count = 0, n_compared = 0, cyc = 0, seed = 32'h204c;
   int gn[3] = '{64, 64, 64}, fn[3] = '{0, 0, 0}, blk[3] = '{0, 0, 0}, offh[3] = '{0, 0, 0};
   tvc_note_s nt;
   tvc_note_s smp_q[$];
   logic [26:0] str_q[$];

   // Block under test and the display driver on its stream
   tvc_top uut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .CLAMP_PULSE_I(clamp_pulse),
      .LINE_SYNC_IN_I(snc), .OUT_EN_N_I(oe_n), .CONV_I(conv), .DATA_O(data), .DATA_OE_O(oe),
      .RED_OVER_RANGE_O(red_over_range), .GREEN_OVER_RANGE_O(green_over_range), .BLUE_OVER_RANGE_O(bor),
      .REF_SELECT_O(refsel), .CLAMP_ACTIVE_O(clact), .CLAMP_LEVEL_O(clvl),
      .PIX_VALID_O(pv), .PIX_READY_I(pr), .PIX_DATA_O(pword));
   tvc_disp_model u_disp (.clk_i(clk), .rst_n_i(rst_n), .hold_i(hold), .slow_i(slow),
      .ready_o(pr));

   always #12.5 clk = ~clk;

   // Takes the oldest note when its sample or stream word appears
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (smp_q.size() > 0 && smp_q[0].due == cyc)
      begin
         nt = smp_q.pop_front();
         `CHK("sample", nt.w, {bor, green_over_range, red_over_range, pins})
      end
      if (str_chk && pv && pr)
      begin
         if (str_q.size() == 0) `CHK("extra word", 1'b0, 1'b1)
         else `CHK("stream word", str_q.pop_front(), pword)
      end
   end

   // Expected word: gain and trim, black subtraction, half-code offset, saturation
   function automatic logic [26:0] expw(input tvc_pix_s c);
      int v;
      int t;
      logic [26:0] w;
      w = '0;
      for (int i = 0; i < 3; i++)
      begin
         v = (int'(c[23 - 8 * i -: 8]) * (gn[i] + fn[i])) >>> 6;
         t = (2 * (v - blk[i]) + offh[i]) >>> 1;
         w[24 + i] = v > 255;
         w[23 - 8 * i -: 8] = t < 0 ? 8'h00 : (t > 255 ? 8'hff : 8'(t));
      end
      return w;
   endfunction

   // One register write cycle
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // One register read, data checked in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      `CHK("read data", e, rdata & m)
   endtask

   // Random converter words, each with its expected output noted
   task automatic burst(input int n);
      tvc_pix_s v;
      repeat (n)
      begin
         @(posedge clk);
         v = tvc_pix_s'(24'($random(seed)));
         conv <= v;
         smp_q.push_back('{cyc + 2, expw(v)});
      end
      repeat (3) @(posedge clk);
   endtask

   // Counts and verdict, then the end of the run
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 3; c++)
      begin
         rreg(4'(3 * c), TVC_STD_ZERO_CODE);
         rreg(4'(3 * c + 1), 8'h20);
         rreg(4'(3 * c + 2), 8'h00);
         rreg(TVC_REG_GAIN_BASE + 4'(c), 8'h40);
      end
      rreg(4'he, 8'h00);
      `CHK("clamp level", 24'h7f7f7f, clvl)
      $display("test reset values done");
      for (int c = 0; c < 3; c++)
      begin
         rnd = 8'($random(seed));
         wreg(4'(3 * c), rnd);
         wreg(4'(3 * c + 1), rnd);
         wreg(4'(3 * c + 2), rnd);
         rreg(4'(3 * c), rnd);
         rreg(4'(3 * c + 1), rnd & 8'h7f);
         rreg(4'(3 * c + 2), rnd & 8'h1f);
         `CHK("clamp level", rnd, clvl[23 - 8 * c -: 8])
         wreg(4'(3 * c), 8'h7f);
         wreg(4'(3 * c + 2), 8'h00);
      end
      wreg(4'he, 8'hff);
      rreg(4'he, 8'h00);
      $display("test register access done");
      `CHK("output enable", 1'b1, oe)
      burst(20);
      oe_n <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK("idle pins", 24'hzzzzzz, pins)
      oe_n <= 1'b0;
      repeat (5) @(posedge clk);
      $display("test sample path done");
      fn = '{31, 16, 0};
      wreg(4'h2, 8'h1f);
      wreg(4'h5, 8'h10);
      burst(20);
      $display("test fine trim done");
      conv <= 24'h2a3c56;
      wreg(4'h1, 8'h2a);
      wreg(4'h4, 8'h3c);
      wreg(4'h7, 8'h56);
      snc <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("reference select", 1'b1, refsel)
      hold <= 1'b1;
      snc <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("reference select", 1'b0, refsel)
      rreg(TVC_REG_STATUS, 8'h04, 8'h04);
      snc <= 1'b1;
      repeat (5) @(posedge clk);
      wreg(TVC_REG_STATUS, 8'h04);
      rreg(TVC_REG_STATUS, 8'h00, 8'h04);
      repeat (TVC_FIFO_DEPTH) str_q.push_back(expw(24'h2a3c56));
      str_chk <= 1'b1;
      slow <= 1'b1;
      hold <= 1'b0;
      repeat (40) @(posedge clk);
      `CHK("words left", 0, str_q.size())
      `CHK("stream valid", 1'b0, pv)
      $display("test stream buffer done");
      str_chk <= 1'b0;
      slow <= 1'b0;
      snc <= 1'b0;
      repeat (4) @(posedge clk);
      conv <= 24'h640a20;
      wreg(4'h1, 8'h20);
      wreg(4'h4, 8'h20);
      wreg(4'h7, 8'h20);
      snc <= 1'b1;
      repeat (90) @(posedge clk);
      rreg(TVC_REG_GAIN_BASE, 8'h15);
      rreg(TVC_REG_GAIN_BASE + 4'h1, {1'b0, TVC_GAIN_MAX});
      rreg(TVC_REG_GAIN_BASE + 4'h2, 8'h40);
      gn = '{21, 127, 64};
      $display("test gain loop done");
      snc <= 1'b0;
      repeat (4) @(posedge clk);
      conv <= 24'h282828;
      clamp_pulse <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK("clamp active", 1'b1, clact)
      clamp_pulse <= 1'b0;
      repeat (5) @(posedge clk);
      for (int i = 0; i < 3; i++) blk[i] = (40 * (gn[i] + fn[i])) >>> 6;
      rreg(TVC_REG_STATUS, 8'h00, 8'h08);
      wreg(4'h0, 8'h83);
      wreg(4'h3, 8'h00);
      offh = '{4, -127, 0};
      burst(20);
      wreg(TVC_REG_CTRL, 8'h01);
      wreg(4'h0, 8'h10);
      wreg(4'h6, 8'hff);
      offh = '{256, 240, 272};
      burst(20);
      conv <= 24'h282828;
      repeat (3) @(posedge clk);
      clamp_pulse <= 1'b1;
      repeat (5) @(posedge clk);
      clamp_pulse <= 1'b0;
      repeat (5) @(posedge clk);
      rreg(TVC_REG_STATUS, 8'h08, 8'h08);
      $display("test clamp done");
      test_done();
   end

   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done();
   end
endmodule
`default_nettype wire
